// file: verilog/hpc_pkg.sv
package hpc_pkg;

    // host port mode selected by the strap pins
    localparam logic [2:0] HPC_MODE_SERIAL  = 3'h0;
    localparam logic [2:0] HPC_MODE_SEP_8   = 3'h1;
    localparam logic [2:0] HPC_MODE_SEP_16  = 3'h2;
    localparam logic [2:0] HPC_MODE_CMB_8   = 3'h3;
    localparam logic [2:0] HPC_MODE_CMB_16  = 3'h4;

    // field positions
    localparam int HPC_SO_BIT      = 7;
    localparam int HPC_DATA_W      = 16;
    localparam int HPC_BYTE_W      = 8;

    // timing, in ns and in 50 ns cycles of sys_clk
    localparam int HPC_CLK_NS      = 50;
    localparam int HPC_SETUP_NS    = 100;
    localparam int HPC_STROBE_NS   = 150;
    localparam int HPC_HOLD_NS     = 100;
    localparam int HPC_SCK_HALF_NS = 250;
    localparam int HPC_SETUP_CYC   = (HPC_SETUP_NS + HPC_CLK_NS - 1) / HPC_CLK_NS;
    localparam int HPC_STROBE_CYC  = (HPC_STROBE_NS + HPC_CLK_NS - 1) / HPC_CLK_NS;
    localparam int HPC_HOLD_CYC    = (HPC_HOLD_NS + HPC_CLK_NS - 1) / HPC_CLK_NS;
    localparam int HPC_SCK_DIV     = (HPC_SCK_HALF_NS + HPC_CLK_NS - 1) / HPC_CLK_NS;

    localparam logic [7:0]  HPC_CNT_ZERO  = 8'h00;
    localparam logic [15:0] HPC_DATA_ZERO = 16'h0000;

    typedef struct packed {
        logic        write;
        logic        first;
        logic [15:0] data;
    } hpc_req_type;

    typedef struct packed {
        logic        cs_n;
        logic        rd_n;
        logic        wr_n;
        logic        start;
    } hpc_ctl_type;

endpackage

// file: verilog/hpc_tick.sv
`timescale 1ns/1ps
module hpc_tick #(
    parameter int DIV = 5
) (
    input  wire logic sys_clk,
    input  wire logic arst_n,
    input  wire logic run,
    output logic      tick
);
    import hpc_pkg::*;

    logic [7:0] cnt_q;

    initial
    begin
        if (DIV < 1 || DIV > 255)
            $error("hpc_tick: DIV out of range");
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_q <= HPC_CNT_ZERO;
            tick  <= 1'b0;
        end
        else if (!run || cnt_q == 8'(DIV - 1))
        begin
            cnt_q <= HPC_CNT_ZERO;
            tick  <= run;
        end
        else
        begin
            cnt_q <= cnt_q + 8'h01;
            tick  <= 1'b0;
        end
    end

endmodule

// file: verilog/hpc_host.sv
`timescale 1ns/1ps
module hpc_host #(
    parameter logic [2:0] MODE      = hpc_pkg::HPC_MODE_SEP_16,
    parameter logic       WAIT_HIGH = 1'b0
) (
    input  wire logic               sys_clk,
    input  wire logic               arst_n,
    input  wire logic               req_valid,
    input  wire hpc_pkg::hpc_req_type req,
    output logic                    req_ready,
    output logic                    rsp_valid,
    output logic [15:0]             rsp_data,
    output logic                    irq_pending,
    output logic [2:0]              host_cfg_sel,
    output logic                    par_chip_sel_n,
    output logic                    par_rd_strobe_n,
    output logic                    par_wr_strobe_n,
    output logic                    cmd_start_mark,
    output logic [15:0]             par_data_out,
    output logic [15:0]             par_data_oe,
    input  wire logic [15:0]        par_data_in,
    input  wire logic               access_wait,
    input  wire logic               host_irq_n
);
    import hpc_pkg::*;

    typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_SER} hpc_state_type;

    initial
    begin
        if (MODE > HPC_MODE_CMB_16)
            $error("hpc_host: unsupported MODE");
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode decode

    wire serial_mode = (MODE == HPC_MODE_SERIAL);
    wire combined    = (MODE == HPC_MODE_CMB_8) || (MODE == HPC_MODE_CMB_16);
    wire wide        = (MODE == HPC_MODE_SEP_16) || (MODE == HPC_MODE_CMB_16);
    wire wait_active = (access_wait == WAIT_HIGH);
    wire [15:0] lane_mask = wide ? 16'hFFFF : 16'h00FF;

    hpc_state_type state_q;
    hpc_state_type state_d;
    logic [7:0]    cnt_q;
    logic [4:0]    bit_q;
    logic          write_q;
    logic          first_q;
    logic [15:0]   shift_q;
    logic          sck_q;
    logic          tick;

    hpc_tick #(
        .DIV (HPC_SCK_DIV)
    ) u_tick (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .run     (state_q == ST_SER),
        .tick    (tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // sequencing

    wire cnt_done = (cnt_q == HPC_CNT_ZERO);
    wire ser_last = tick && sck_q && (bit_q == 5'(HPC_DATA_W - 1));
    // wait only stretches the strobe phase; ignored once the strobe ends
    wire strobe_end = cnt_done && !wait_active;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
                if (req_valid)
                    state_d = serial_mode ? ST_SER : ST_SETUP;
            ST_SETUP:
                if (cnt_done)
                    state_d = ST_STROBE;
            ST_STROBE:
                if (strobe_end)
                    state_d = ST_HOLD;
            ST_HOLD:
                if (cnt_done)
                    state_d = ST_IDLE;
            ST_SER:
                if (ser_last)
                    state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
    end

    wire enter_par  = (state_q == ST_IDLE) && req_valid && !serial_mode;
    wire enter_ser  = (state_q == ST_IDLE) && req_valid && serial_mode;
    wire enter_str  = (state_q == ST_SETUP) && cnt_done;
    wire enter_hold = (state_q == ST_STROBE) && strobe_end;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= ST_IDLE;
            cnt_q   <= HPC_CNT_ZERO;
        end
        else
        begin
            state_q <= state_d;
            if (enter_par)
                cnt_q <= 8'(HPC_SETUP_CYC - 1);
            else if (enter_str)
                cnt_q <= 8'(HPC_STROBE_CYC - 1);
            else if (enter_hold)
                cnt_q <= 8'(HPC_HOLD_CYC - 1);
            else if (!cnt_done)
                cnt_q <= cnt_q - 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // request capture and serial shifter

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            write_q <= 1'b0;
            first_q <= 1'b0;
            shift_q <= HPC_DATA_ZERO;
            bit_q   <= 5'h00;
            sck_q   <= 1'b0;
        end
        else if (enter_par || enter_ser)
        begin
            write_q <= req.write;
            first_q <= req.first;
            shift_q <= req.data;
            bit_q   <= 5'h00;
            sck_q   <= 1'b0;
        end
        else if (state_q == ST_SER && tick)
        begin
            // device launches on falling, we sample on rising sck
            sck_q <= !sck_q;
            if (!sck_q)
                shift_q <= {shift_q[14:0], par_data_in[HPC_SO_BIT]};
            else
                bit_q <= bit_q + 5'h01;
        end
        else if (enter_hold && !write_q)
            shift_q <= par_data_in & lane_mask;
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin drive

    wire in_par   = (state_q == ST_SETUP) || (state_q == ST_STROBE) || (state_q == ST_HOLD);
    wire in_ser   = (state_q == ST_SER);
    wire strobing = (state_q == ST_STROBE);
    wire idle_next = (state_d == ST_IDLE);

    hpc_ctl_type ctl_d;
    always_comb
    begin
        ctl_d.cs_n  = !(in_par || in_ser) || idle_next;
        ctl_d.start = in_par && first_q && !idle_next;
        if (in_ser)
        begin
            ctl_d.rd_n = shift_q[15];
            ctl_d.wr_n = sck_q;
        end
        else if (combined)
        begin
            ctl_d.rd_n = in_par ? !write_q : 1'b1;
            // pins lag the state by one register, so the whole strobe state is kept
            ctl_d.wr_n = !strobing;
        end
        else
        begin
            ctl_d.rd_n = !(strobing && !write_q);
            ctl_d.wr_n = !(strobing && write_q);
        end
    end

    // serial data must be presented on the next output from the new shift value
    wire ser_bit = enter_ser ? req.data[15] : (in_ser ? shift_q[15] : 1'b1);

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            par_chip_sel_n  <= 1'b1;
            par_rd_strobe_n <= 1'b1;
            par_wr_strobe_n <= 1'b1;
            cmd_start_mark  <= 1'b0;
            par_data_out    <= HPC_DATA_ZERO;
            par_data_oe     <= HPC_DATA_ZERO;
            req_ready       <= 1'b0;
            rsp_valid       <= 1'b0;
            rsp_data        <= HPC_DATA_ZERO;
            irq_pending     <= 1'b0;
            host_cfg_sel    <= HPC_MODE_SERIAL;
        end
        else
        begin
            host_cfg_sel    <= MODE;
            par_chip_sel_n  <= ctl_d.cs_n;
            cmd_start_mark  <= ctl_d.start;
            par_wr_strobe_n <= ctl_d.wr_n;
            par_rd_strobe_n <= (in_ser && !enter_ser) ? shift_q[15] :
                               (enter_ser ? ser_bit : ctl_d.rd_n);
            // host drives the bus only for a parallel write; device owns it on reads
            par_data_out    <= write_q ? (shift_q & lane_mask) : HPC_DATA_ZERO;
            par_data_oe     <= (in_par && write_q && !idle_next) ? lane_mask : HPC_DATA_ZERO;
            req_ready       <= idle_next && !(state_q == ST_IDLE && req_valid);
            rsp_valid       <= (state_q != ST_IDLE) && idle_next;
            if ((state_q != ST_IDLE) && idle_next)
                rsp_data <= write_q ? HPC_DATA_ZERO : shift_q;
            irq_pending     <= !host_irq_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_strobe_needs_cs: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (!par_rd_strobe_n && !serial_mode && !combined) |-> !par_chip_sel_n)
        else $error("read strobe low without chip select");

    a_write_needs_cs: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (!par_wr_strobe_n && !serial_mode) |-> !par_chip_sel_n)
        else $error("write strobe low without chip select");

    a_no_rd_wr_overlap: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (!serial_mode && !combined) |-> (par_rd_strobe_n || par_wr_strobe_n))
        else $error("read and write strobes both low");

    a_oe_only_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (par_data_oe != HPC_DATA_ZERO) |-> (!par_chip_sel_n && (serial_mode == 1'b0)))
        else $error("bus driven outside a write");

    a_wait_stretch: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (strobing && wait_active) |=> (state_q == ST_STROBE))
        else $error("strobe ended while wait active");

    a_start_with_cs: assert property (@(posedge sys_clk) disable iff (!arst_n)
        cmd_start_mark |-> !par_chip_sel_n)
        else $error("start mark without chip select");

    a_ser_cs_held: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (in_ser && $past(in_ser)) |-> !par_chip_sel_n)
        else $error("slave select released mid transfer");

    a_irq_follow: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !host_irq_n |=> irq_pending)
        else $error("interrupt not reported");

    a_upper_masked: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !wide |-> (par_data_oe[15:8] == 8'h00))
        else $error("upper byte driven in 8-bit mode");

endmodule

// file: test/hpc_dev_model.sv
`timescale 1ns/1ps
module hpc_dev_model (
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic [2:0]  cfg,
    input  wire logic        cs_n,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic        start,
    input  wire logic [15:0] host_oe,
    input  wire logic [15:0] bus,
    input  wire logic [3:0]  wait_cyc,
    input  wire logic [15:0] rd_val,
    input  wire logic        irq_req,
    output logic [15:0]      dev_line,
    output logic             access_wait,
    output logic             host_irq_n,
    output logic [15:0]      wr_data_q,
    output logic             start_q,
    output logic [7:0]       low_len_q,
    output logic             err_q
);
    import hpc_pkg::*;
    logic        par;
    logic        sep;
    logic        rd_act;
    logic        wr_act;
    logic        act;
    logic [7:0]  cnt_q;
    logic [15:0] last_q;
    assign par = cfg != HPC_MODE_SERIAL;
    assign sep = cfg == HPC_MODE_SEP_8 || cfg == HPC_MODE_SEP_16;
    assign rd_act = par && !cs_n && (sep ? !rd_n : (rd_n && !wr_n));
    assign wr_act = par && !cs_n && (sep ? !wr_n : (!rd_n && !wr_n));
    assign act = rd_act || wr_act;
    // released: bit 7 pulled down, the rest show the last read value inverted
    assign dev_line = rd_act ? rd_val : {~last_q[15:8], 1'b0, ~last_q[6:0]};
    // active low wait; stretches from the strobe's first cycle on
    assign access_wait = !(act && cnt_q < {4'h0, wait_cyc});
    assign host_irq_n = !irq_req;
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_q     <= 8'h00;
            low_len_q <= 8'h00;
            wr_data_q <= 16'h0000;
            start_q   <= 1'b0;
            last_q    <= 16'h0000;
            err_q     <= 1'b0;
        end
        else
        begin
            cnt_q <= act ? cnt_q + 8'h01 : 8'h00;
            if (act)
                low_len_q <= cnt_q + 8'h01;
            if (wr_act)
                wr_data_q <= bus;
            if (act)
                start_q <= start;
            if (rd_act)
                last_q <= rd_val;
            if ((sep && cs_n && (!rd_n || !wr_n)) || (rd_act && host_oe != 16'h0000))
                err_q <= 1'b1;
        end
    end
endmodule

// file: test/testbench.sv
`timescale 1ns/1ps
module testbench;
    import hpc_pkg::*;
    localparam logic [2:0] MODE = HPC_MODE_SEP_16;
    logic        sys_clk, arst_n, req_valid, req_ready, rsp_valid, irq_pending;
    logic        cs_n, rd_n, wr_n, start, access_wait, host_irq_n, irq_req;
    logic        start_q, err_q, w, f;
    hpc_req_type req;
    logic [2:0]  cfg;
    logic [3:0]  wait_cyc;
    logic [7:0]  low_len_q;
    logic [15:0] rsp_data, par_data_out, par_data_oe, par_data_in, dev_line;
    logic [15:0] wr_data_q, rd_val, rdata, d;
    int          n_errors, check_count, cycles;
    assign par_data_in = (par_data_oe & par_data_out) | (~par_data_oe & dev_line);
    hpc_host #(.MODE(MODE), .WAIT_HIGH(1'b0)) dut (.sys_clk(sys_clk), .arst_n(arst_n),
        .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .irq_pending(irq_pending), .host_cfg_sel(cfg),
        .par_chip_sel_n(cs_n), .par_rd_strobe_n(rd_n), .par_wr_strobe_n(wr_n),
        .cmd_start_mark(start), .par_data_out(par_data_out), .par_data_oe(par_data_oe),
        .par_data_in(par_data_in), .access_wait(access_wait), .host_irq_n(host_irq_n));
    hpc_dev_model partner (.sys_clk(sys_clk), .arst_n(arst_n), .cfg(cfg), .cs_n(cs_n),
        .rd_n(rd_n), .wr_n(wr_n), .start(start), .host_oe(par_data_oe), .bus(par_data_in),
        .wait_cyc(wait_cyc), .rd_val(rd_val), .irq_req(irq_req), .dev_line(dev_line),
        .access_wait(access_wait), .host_irq_n(host_irq_n), .wr_data_q(wr_data_q),
        .start_q(start_q), .low_len_q(low_len_q), .err_q(err_q));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] exp_rsp(input logic wr, input logic [15:0] v);
        logic [15:0] mask;
        mask = (MODE == HPC_MODE_SEP_8 || MODE == HPC_MODE_CMB_8) ? 16'h00ff : 16'hffff;
        return wr ? 16'h0000 : (v & mask);
    endfunction
    task automatic check(input bit ok, input string msg);
        check_count++;
        if (!ok)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    endtask
    task automatic report_and_stop();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // one whole access; request held until the edge that takes it
    task automatic access(input logic wr, input logic fi, input logic [15:0] v,
                          output logic [15:0] r);
        int n;
        @(negedge sys_clk);
        req_valid = 1'b1;
        req = '{write: wr, first: fi, data: v};
        n = 0;
        while (req_ready !== 1'b1 && n < 200)
        begin
            @(negedge sys_clk);
            n++;
        end
        @(negedge sys_clk);
        req_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 200)
        begin
            @(negedge sys_clk);
            n++;
        end
        r = rsp_data;
        check(n < 200, "access never completed");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t run timed out", $time);
            report_and_stop();
        end
    end
    initial
    begin
        arst_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        wait_cyc = 4'h0;
        rd_val = 16'h0000;
        irq_req = 1'b0;
        void'($urandom(87));
        repeat (8) @(negedge sys_clk);
        arst_n = 1'b1;
        repeat (2) @(negedge sys_clk);
        check(cfg === MODE, "strap value");
        check(cs_n === 1'b1 && rd_n === 1'b1 && wr_n === 1'b1, "idle pins");
        for (int i = 0; i < 24; i++)
        begin
            w = (i < 4) ? i[0] : 1'($urandom % 2);
            f = 1'($urandom % 2);
            d = (i < 2) ? 16'hffff : 16'($urandom);
            wait_cyc = (i < 4) ? 4'h0 : ((i < 8) ? 4'h7 : 4'($urandom % 8));
            rd_val = (i < 4) ? 16'ha5a5 : 16'($urandom);
            access(w, f, d, rdata);
            check(rdata === exp_rsp(w, w ? d : rd_val), "response data");
            if (w)
                check(wr_data_q === d, "written data");
            check(start_q === f, "start marker");
            check(low_len_q >= 8'(HPC_STROBE_CYC) && low_len_q > {4'h0, wait_cyc},
                  "strobe not stretched");
        end
        irq_req = 1'b1;
        repeat (2) @(negedge sys_clk);
        check(irq_pending === 1'b1, "interrupt missed");
        irq_req = 1'b0;
        repeat (2) @(negedge sys_clk);
        check(irq_pending === 1'b0, "interrupt stuck");
        check(err_q === 1'b0, "strobe unselected or bus contention");
        report_and_stop();
    end
endmodule
